// ===== dv/tb.sv
// Self-checking bench for the port 3 upper pin configuration register
module tb
   import port3_upper_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   reg_req_t req = '0;
   logic [7:0] rdat;
   // Pad inputs start apart so the first sync step shows known old values
   logic rval, d4 = 1'b0, d5 = 1'b0, i4 = 1'b0, i5 = 1'b1;
   logic o4, e4, p4, o5, e5, p5, s4, s5, split;
   int miscompares = 0;
   int total_checks = 0;

   // 25 MHz core clock
   always #20 clk_sys = ~clk_sys;

   port3_upper_pin_config DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .reg_req(req), .rd_data_ff(rdat), .rd_valid_ff(rval),
      .port3_bit4_data(d4), .port3_bit5_data(d5),
      .port3_bit4_pin_in(i4), .port3_bit5_pin_in(i5),
      .port3_bit4_pin_out_ff(o4), .port3_bit4_pin_oe_ff(e4),
      .port3_bit4_pull_en_ff(p4), .port3_bit5_pin_out_ff(o5),
      .port3_bit5_pin_oe_ff(e5), .port3_bit5_pull_en_ff(p5),
      .port3_bit4_in_sync_ff(s4), .port3_bit5_in_sync_ff(s5),
      .port4_split_sel_ff(split));

   // Compare and count
   task chk(input string what, input logic [7:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim

   // One register access, held for one edge
   task acc(input logic [7:0] a, input logic [2:0] sbm, input logic w,
      input logic [7:0] wd);
      @(negedge clk_sys);
      req = '{a, sbm[2], sbm[1], sbm[0], w, ~w, wd};
      @(negedge clk_sys);
      req = '0;
   endtask : acc

   // Read back the register and compare
   task rd_chk(input logic [7:0] exp);
      acc(CFG_ADDR, 3'b111, 1'b0, 8'h00);
      chk("rd_valid", {7'h0, rval}, 8'h01);
      chk("rd_data", rdat, exp);
   endtask : rd_chk

   // Drive both data bits, then judge pad drive of both pins
   task pads(input logic [1:0] mu, ml, input logic d);
      @(negedge clk_sys);
      d4 = d;
      d5 = d;
      @(negedge clk_sys);
      chk("pin5", {5'h0, e5, p5, o5 & (mu == 2'h1 || mu == 2'h2)},
         {5'h0, mu == 2'h1 ? ~d : mu == 2'h2, mu == 2'h3,
         mu == 2'h2 ? d : 1'b0});
      chk("pin4", {5'h0, e4, p4, o4 & (ml == 2'h1 || ml == 2'h2)},
         {5'h0, ml == 2'h1 ? ~d : ml == 2'h2, ml == 2'h3,
         ml == 2'h2 ? d : 1'b0});
   endtask : pads

   task t_reset;
      rd_chk(8'h50);
      chk("split", {7'h0, split}, 8'h00);
      pads(2'h1, 2'h1, 1'b0);
      pads(2'h1, 2'h1, 1'b1);
      $display("test reset done");
   endtask : t_reset

   task t_modes;
      for (int m = 0; m < 4; m++)
      begin
         acc(CFG_ADDR, 3'b111, 1'b1, {m[1:0], 2'(3 - m), 4'h0});
         @(negedge clk_sys);
         pads(m[1:0], 2'(3 - m), 1'b0);
         pads(m[1:0], 2'(3 - m), 1'b1);
      end
      $display("test modes done");
   endtask : t_modes

   task t_bits;
      acc(CFG_ADDR, 3'b111, 1'b1, 8'hFF);
      rd_chk(8'hF1);
      chk("split", {7'h0, split}, 8'h01);
      acc(CFG_ADDR, 3'b111, 1'b1, 8'h0E);
      rd_chk(8'h00);
      chk("split", {7'h0, split}, 8'h00);
      $display("test bits done");
   endtask : t_bits

   // Reset in mid-run returns the register and pads to reset state
   task t_rerun;
      acc(CFG_ADDR, 3'b111, 1'b1, 8'hA1);
      @(negedge clk_sys);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      sys_rst = 1'b0;
      rd_chk(8'h50);
      chk("split", {7'h0, split}, 8'h00);
      pads(2'h1, 2'h1, 1'b1);
      $display("test mid reset done");
   endtask : t_rerun

   task t_refuse;
      acc(CFG_ADDR, 3'b111, 1'b1, 8'h50);
      acc(8'hE0, 3'b111, 1'b1, 8'hA1);
      acc(CFG_ADDR, 3'b011, 1'b1, 8'hA1);
      acc(CFG_ADDR, 3'b101, 1'b1, 8'hA1);
      acc(CFG_ADDR, 3'b110, 1'b1, 8'hA1);
      rd_chk(8'h50);
      acc(8'hE0, 3'b111, 1'b0, 8'h00);
      chk("rd_valid_miss", {7'h0, rval}, 8'h00);
      $display("test refuse done");
   endtask : t_refuse

   task t_sync;
      for (int v = 1; v >= 0; v--)
      begin
         @(negedge clk_sys);
         i4 = v[0];
         i5 = ~v[0];
         @(negedge clk_sys);
         chk("sync_early", {6'h0, s5, s4}, {6'h0, v[0], ~v[0]});
         @(negedge clk_sys);
         chk("sync", {6'h0, s5, s4}, {6'h0, ~v[0], v[0]});
      end
      $display("test sync done");
   endtask : t_sync

   // Main sequence
   initial
   begin
      repeat (8) @(negedge clk_sys);
      sys_rst = 1'b0;
      t_reset();
      t_modes();
      t_bits();
      t_rerun();
      t_refuse();
      t_sync();
      end_sim();
   end

   // Watchdog
   initial
   begin
      #(40 * 2000);
      miscompares++;
      end_sim();
   end
endmodule : tb

// ===== src/pin_mode_cell.sv
// Mode decoder for one port pin: turns mode and data bit into pad drive
module pin_mode_cell
   import port3_upper_pkg::*;
(
   input wire logic [1:0] mode,
   input wire logic data_bit,
   output pin_drive_t drive
);

   pin_mode_t mode_sel;
   logic is_od;
   logic is_pp;

   // Decode the mode field
   assign mode_sel = pin_mode_t'(mode);
   assign is_od = (mode_sel == MODE_OPEN_DRAIN);
   assign is_pp = (mode_sel == MODE_PUSH_PULL);

   // Open drain only pulls low; push-pull drives both levels
   assign drive.oe = is_pp | (is_od & ~data_bit);
   assign drive.out = is_pp & data_bit;
   assign drive.pull_en = (mode_sel == MODE_IN_PULLUP);

endmodule : pin_mode_cell

// ===== src/port3_upper_pin_config.sv
// Port 3 upper pin configuration register with pad drive for two pins
module port3_upper_pin_config
   import port3_upper_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input reg_req_t reg_req,
   output logic [7:0] rd_data_ff,
   output logic rd_valid_ff,
   input wire logic port3_bit4_data,
   input wire logic port3_bit5_data,
   input wire logic port3_bit4_pin_in,
   input wire logic port3_bit5_pin_in,
   output logic port3_bit4_pin_out_ff,
   output logic port3_bit4_pin_oe_ff,
   output logic port3_bit4_pull_en_ff,
   output logic port3_bit5_pin_out_ff,
   output logic port3_bit5_pin_oe_ff,
   output logic port3_bit5_pull_en_ff,
   output logic port3_bit4_in_sync_ff,
   output logic port3_bit5_in_sync_ff,
   output logic port4_split_sel_ff
);

   logic [7:0] cfg_ff;
   logic [7:0] nxt_cfg;
   logic addr_hit;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] cfg_readback;
   logic [PIN_COUNT-1:0] pin_data;
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_meta_ff;
   logic [PIN_COUNT-1:0] pin_sync_ff;
   pin_drive_t drive_lower;
   pin_drive_t drive_upper;

   // Address decode, register addressing only
   assign addr_hit = (reg_req.addr == CFG_ADDR)
      & (reg_req.set1 == CFG_SET1)
      & (reg_req.bank == CFG_BANK)
      & reg_req.reg_mode;
   assign wr_hit = addr_hit & reg_req.wr;
   assign rd_hit = addr_hit & reg_req.rd;

   // Only implemented bits are stored
   assign nxt_cfg = wr_hit ? (reg_req.wdata & CFG_IMPL_MASK) : cfg_ff;
   assign cfg_readback = cfg_ff & CFG_IMPL_MASK;

   // Configuration register
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         cfg_ff <= CFG_RESET;
      end
      else
      begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Read port, zero outside a hit
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         rd_data_ff <= CFG_ZERO;
         rd_valid_ff <= 1'b0;
      end
      else
      begin
         rd_data_ff <= rd_hit ? cfg_readback : CFG_ZERO;
         rd_valid_ff <= rd_hit;
      end
   end

   // Pin inputs pass two flip-flops
   assign pin_raw = {port3_bit5_pin_in, port3_bit4_pin_in};
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
      end
      else
      begin
         pin_meta_ff <= pin_raw;
         pin_sync_ff <= pin_meta_ff;
      end
   end
   assign port3_bit4_in_sync_ff = pin_sync_ff[PIN_LOWER];
   assign port3_bit5_in_sync_ff = pin_sync_ff[PIN_UPPER];

   // Mode decoders for upper and lower pin
   assign pin_data = {port3_bit5_data, port3_bit4_data};

   pin_mode_cell u_upper_cell (
      .mode (cfg_ff[UPPER_MODE_HI:UPPER_MODE_LO]),
      .data_bit (pin_data[PIN_UPPER]),
      .drive (drive_upper)
   );

   pin_mode_cell u_lower_cell (
      .mode (cfg_ff[LOWER_MODE_HI:LOWER_MODE_LO]),
      .data_bit (pin_data[PIN_LOWER]),
      .drive (drive_lower)
   );

   // Registered pad drive; reset leaves pads released, as open drain high
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         port3_bit5_pin_oe_ff <= 1'b0;
         port3_bit5_pin_out_ff <= 1'b0;
         port3_bit5_pull_en_ff <= 1'b0;
         port3_bit4_pin_oe_ff <= 1'b0;
         port3_bit4_pin_out_ff <= 1'b0;
         port3_bit4_pull_en_ff <= 1'b0;
      end
      else
      begin
         port3_bit5_pin_oe_ff <= drive_upper.oe;
         port3_bit5_pin_out_ff <= drive_upper.out;
         port3_bit5_pull_en_ff <= drive_upper.pull_en;
         port3_bit4_pin_oe_ff <= drive_lower.oe;
         port3_bit4_pin_out_ff <= drive_lower.out;
         port3_bit4_pull_en_ff <= drive_lower.pull_en;
      end
   end

   // Port 4 control arrangement select
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         port4_split_sel_ff <= 1'b0;
      end
      else
      begin
         port4_split_sel_ff <= cfg_ff[SPLIT_SEL_BIT];
      end
   end

   // Checks on register and pad behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   property p_reset_value;
      $fell(sys_rst) |-> (cfg_ff == CFG_RESET) && !port4_split_sel_ff;
   endproperty
   a_reset_value: assert property (p_reset_value)
      else $error("config not 50h after reset");

   property p_upper_push_pull;
      (cfg_ff[UPPER_MODE_HI:UPPER_MODE_LO] == MODE_PUSH_PULL)
         |=> port3_bit5_pin_oe_ff
         && (port3_bit5_pin_out_ff == $past(port3_bit5_data));
   endproperty
   a_upper_push_pull: assert property (p_upper_push_pull)
      else $error("upper pin push-pull drive wrong");

   property p_upper_input;
      (cfg_ff[UPPER_MODE_HI] == 1'b0 || cfg_ff[UPPER_MODE_LO] == 1'b1)
         && (cfg_ff[UPPER_MODE_HI:UPPER_MODE_LO] != MODE_OPEN_DRAIN)
         |=> !port3_bit5_pin_oe_ff
         && (port3_bit5_pull_en_ff == $past(cfg_ff[UPPER_MODE_HI]));
   endproperty
   a_upper_input: assert property (p_upper_input)
      else $error("upper pin input mode drive or pull wrong");

   property p_lower_open_drain;
      (cfg_ff[LOWER_MODE_HI:LOWER_MODE_LO] == MODE_OPEN_DRAIN)
         |=> (port3_bit4_pin_oe_ff == !$past(port3_bit4_data))
         && !port3_bit4_pin_out_ff && !port3_bit4_pull_en_ff;
   endproperty
   a_lower_open_drain: assert property (p_lower_open_drain)
      else $error("lower pin open-drain drive wrong");

   property p_lower_pullup;
      (cfg_ff[LOWER_MODE_HI:LOWER_MODE_LO] == MODE_IN_PULLUP)
         |=> port3_bit4_pull_en_ff && !port3_bit4_pin_oe_ff;
   endproperty
   a_lower_pullup: assert property (p_lower_pullup)
      else $error("lower pin pull-up input wrong");

   property p_split_select;
      wr_hit |-> ##2
         (port4_split_sel_ff == $past(reg_req.wdata[SPLIT_SEL_BIT], 2));
   endproperty
   a_split_select: assert property (p_split_select)
      else $error("port 4 select does not follow write");

   property p_unused_zero;
      wr_hit |=> (cfg_ff[UNUSED_HI:UNUSED_LO] == 3'h0)
         ##1 (rd_data_ff[UNUSED_HI:UNUSED_LO] == 3'h0);
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unimplemented bits took a value");

   property p_decode_only;
      reg_req.wr && !addr_hit |=> $stable(cfg_ff);
   endproperty
   a_decode_only: assert property (p_decode_only)
      else $error("config changed on foreign access");

   property p_read_back;
      rd_hit && !wr_hit |=> rd_valid_ff
         && (rd_data_ff == ($past(cfg_ff) & CFG_IMPL_MASK));
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("read data does not match config");

endmodule : port3_upper_pin_config

// ===== src/port3_upper_pkg.sv
// Constants, modes and carriers for the port 3 upper pin configuration
package port3_upper_pkg;

   // Register location in the register file
   localparam logic [7:0] CFG_ADDR = 8'hE1;
   localparam logic CFG_SET1 = 1'h1;
   localparam logic CFG_BANK = 1'h1;

   // Reset value and implemented bits
   localparam logic [7:0] CFG_RESET = 8'h50;
   localparam logic [7:0] CFG_IMPL_MASK = 8'hF1;
   localparam logic [7:0] CFG_ZERO = 8'h00;

   // Field positions
   localparam int UPPER_MODE_HI = 7;
   localparam int UPPER_MODE_LO = 6;
   localparam int LOWER_MODE_HI = 5;
   localparam int LOWER_MODE_LO = 4;
   localparam int UNUSED_HI = 3;
   localparam int UNUSED_LO = 1;
   localparam int SPLIT_SEL_BIT = 0;

   // Pin indices within the two-pin vectors
   localparam int PIN_LOWER = 0;
   localparam int PIN_UPPER = 1;
   localparam int PIN_COUNT = 2;

   // Pin mode encodings
   typedef enum logic [1:0] {
      MODE_CMOS_IN = 2'h0,
      MODE_OPEN_DRAIN = 2'h1,
      MODE_PUSH_PULL = 2'h2,
      MODE_IN_PULLUP = 2'h3
   } pin_mode_t;

   // Register access request from the CPU core
   typedef struct packed {
      logic [7:0] addr;
      logic set1;
      logic bank;
      logic reg_mode;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;

   // Drive of one pin pad
   typedef struct packed {
      logic oe;
      logic out;
      logic pull_en;
   } pin_drive_t;

endpackage : port3_upper_pkg
